// File: rtl/flash_host_ctrl.v
`timescale 1ns/10ps
`default_nettype none
`include "flash_host_regs.vh"

// Function
// - Reset pin held low at least 100ns; device floats and powers down.
// - After reset mode may be array or interrupted; host reads status.
// - Write needs write strobe and select low; latched at first rise.
// - Pin levels choose read, write, standby, output disable or reset.
// - Host holds write-protect high while programming or erasing.
// - Status latched on select or output enable fall; toggle between reads.
// - Sector erase is 20H then D0H at an address in the sector.
// - Word write is 40H or 10H then address and data.
// - Protection program is C0H then data to a protection address.
module flash_host_ctrl #(
    parameter [7:0] WP_CYC = `WR_PULSE_CYC_DEF,
    parameter [7:0] ACC_CYC = `ACCESS_CYC_DEF,
    parameter [7:0] EXIT_CYC = `EXIT_CYC_DEF
) (
    input wire clk_sys,
    input wire rst_b,
    input wire [7:0] reg_addr,
    input wire [31:0] reg_wdata,
    input wire reg_wr,
    input wire reg_rd,
    output wire [31:0] reg_rdata,
    input wire prog_supply_ok,
    output wire [21:0] flash_addr,
    input wire [15:0] data_pins_in,
    output wire [15:0] data_pins_out,
    output wire data_pins_oe,
    output wire flash_ce_b,
    output wire flash_oe_b,
    output wire flash_we_b,
    output wire flash_rst_b,
    output wire flash_wp
);

    localparam [7:0] S_IDLE = 8'h01;
    localparam [7:0] S_RLOW = 8'h02;
    localparam [7:0] S_RWAIT = 8'h04;
    localparam [7:0] S_WSET = 8'h08;
    localparam [7:0] S_WPUL = 8'h10;
    localparam [7:0] S_WHLD = 8'h20;
    localparam [7:0] S_RACC = 8'h40;
    localparam [7:0] S_GAP = 8'h80;
    localparam integer RST_CYC_INT = `RST_LOW_CYC;
    localparam [7:0] RST_CYC = RST_CYC_INT[7:0];

    reg [7:0] state_ff;
    reg [7:0] cnt_ff;
    reg [21:0] addr_ff;
    reg [15:0] wdata_ff;
    reg cfg_wp_ff;
    reg refused_ff;
    reg [1:0] mode_ff;
    reg [1:0] pmode_ff;
    reg [15:0] rdata_ff;
    reg clean_ff;
    reg after_rst_ff;
    reg [15:0] w2_ff;
    reg two_ff;
    reg rd_pend_ff;
    reg [21:0] fa_ff;
    reg [15:0] dq_out_ff;
    reg dq_oe_ff;
    reg ce_b_ff;
    reg oe_b_ff;
    reg we_b_ff;
    reg rst_pin_b_ff;
    reg wp_ff;
    reg [31:0] bus_rdata_ff;

    wire cmd_go = reg_wr && (reg_addr == `REG_CMD);
    wire stat_clr = reg_wr && (reg_addr == `REG_STAT) && reg_wdata[`STAT_REFUSED];
    wire [2:0] op = reg_wdata[`CMD_OP_MSB:`CMD_OP_LSB];
    wire [7:0] code = reg_wdata[`CMD_CODE_MSB:`CMD_CODE_LSB];
    wire idle = (state_ff == S_IDLE);
    reg single_ok;
    reg [1:0] single_mode;
    reg seq_ok;
    reg needs_supply;

    ////////////////////////////////////////////////////////////////////////////
    // Order decode
    always @* begin
        single_ok = 1'b1;
        single_mode = mode_ff;
        seq_ok = 1'b1;
        needs_supply = 1'b1;
        case (code)
            `FC_READ_ARRAY: single_mode = `MODE_ARRAY;
            `FC_READ_CONFIG: single_mode = `MODE_CONFIG;
            `FC_READ_QUERY: single_mode = `MODE_QUERY;
            `FC_READ_STATUS: single_mode = `MODE_STATUS;
            `FC_CLEAR_STATUS: single_mode = mode_ff;
            `FC_SUSPEND: single_mode = `MODE_STATUS;
            `FC_CONFIRM: single_mode = `MODE_STATUS;
            default: single_ok = 1'b0;
        endcase
        case (code)
            `FC_ERASE_SETUP: needs_supply = 1'b1;
            `FC_WRITE_SETUP: needs_supply = 1'b1;
            `FC_WRITE_ALT: needs_supply = 1'b1;
            `FC_LOCK_SETUP: needs_supply = 1'b1;
            `FC_PROT_SETUP: needs_supply = 1'b0;
            default: seq_ok = 1'b0;
        endcase
        // Altering sequences except protection program (C0H) are held back while the supply is invalid
        if (needs_supply && !prog_supply_ok) begin
            seq_ok = 1'b0;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Software registers
    always @(posedge clk_sys or negedge rst_b) begin
        if (!rst_b) begin
            addr_ff <= 22'h000000;
            wdata_ff <= 16'h0000;
            cfg_wp_ff <= `CFG_WP_RST;
        end else if (reg_wr) begin
            case (reg_addr)
                `REG_ADDR: addr_ff <= reg_wdata[21:0];
                `REG_WDATA: wdata_ff <= reg_wdata[15:0];
                `REG_CFG: cfg_wp_ff <= reg_wdata[`CFG_WP];
                default: cfg_wp_ff <= cfg_wp_ff;
            endcase
        end
    end

    // Read data, one cycle after the read strobe, zero otherwise
    always @(posedge clk_sys or negedge rst_b) begin
        if (!rst_b) begin
            bus_rdata_ff <= 32'h00000000;
        end else if (reg_rd) begin
            case (reg_addr)
                `REG_ADDR: bus_rdata_ff <= {10'h000, addr_ff};
                `REG_WDATA: bus_rdata_ff <= {16'h0000, wdata_ff};
                `REG_RDATA: bus_rdata_ff <= {16'h0000, rdata_ff};
                `REG_STAT: bus_rdata_ff <= {26'h0000000, clean_ff, prog_supply_ok,
                    mode_ff, refused_ff, !idle};
                `REG_CFG: bus_rdata_ff <= {31'h00000000, cfg_wp_ff};
                default: bus_rdata_ff <= 32'h00000000;
            endcase
        end else begin
            bus_rdata_ff <= 32'h00000000;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Pin sequencer
    always @(posedge clk_sys or negedge rst_b) begin
        if (!rst_b) begin
            state_ff <= S_IDLE;
            cnt_ff <= 8'h00;
            refused_ff <= 1'b0;
            mode_ff <= `MODE_ARRAY;
            pmode_ff <= `MODE_ARRAY;
            rdata_ff <= 16'h0000;
            clean_ff <= 1'b0;
            after_rst_ff <= 1'b0;
            w2_ff <= 16'h0000;
            two_ff <= 1'b0;
            rd_pend_ff <= 1'b0;
            fa_ff <= 22'h000000;
            dq_out_ff <= 16'h0000;
            dq_oe_ff <= 1'b0;
            ce_b_ff <= 1'b1;
            oe_b_ff <= 1'b1;
            we_b_ff <= 1'b1;
            rst_pin_b_ff <= 1'b1;
            wp_ff <= `CFG_WP_RST;
        end else begin
            // Refused order flag: a new refusal wins over the clear
            if (cmd_go && (!idle || !((op == `OP_SINGLE && single_ok) ||
                (op == `OP_SEQ && seq_ok) || op == `OP_READ || op == `OP_RESET))) begin
                refused_ff <= 1'b1;
            end else if (stat_clr) begin
                refused_ff <= 1'b0;
            end
            case (state_ff)
                S_IDLE: begin
                    wp_ff <= cfg_wp_ff;
                    // Idle keeps select high so the device sits in standby
                    ce_b_ff <= 1'b1;
                    if (cmd_go && op == `OP_SINGLE && single_ok) begin
                        fa_ff <= addr_ff;
                        dq_out_ff <= {8'h00, code};
                        dq_oe_ff <= 1'b1;
                        ce_b_ff <= 1'b0;
                        two_ff <= 1'b0;
                        rd_pend_ff <= 1'b0;
                        pmode_ff <= single_mode;
                        state_ff <= S_WSET;
                    end else if (cmd_go && op == `OP_SEQ && seq_ok) begin
                        fa_ff <= addr_ff;
                        dq_out_ff <= {8'h00, code};
                        dq_oe_ff <= 1'b1;
                        ce_b_ff <= 1'b0;
                        wp_ff <= 1'b1;
                        // Erase confirm is fixed, others carry the data word
                        w2_ff <= (code == `FC_ERASE_SETUP) ? {8'h00, `FC_CONFIRM} :
                            wdata_ff;
                        two_ff <= 1'b1;
                        rd_pend_ff <= 1'b0;
                        pmode_ff <= `MODE_STATUS;
                        state_ff <= S_WSET;
                    end else if (cmd_go && op == `OP_READ) begin
                        fa_ff <= addr_ff;
                        ce_b_ff <= 1'b0;
                        oe_b_ff <= 1'b0;
                        cnt_ff <= ACC_CYC - 8'h01;
                        pmode_ff <= mode_ff;
                        state_ff <= S_RACC;
                    end else if (cmd_go && op == `OP_RESET) begin
                        rst_pin_b_ff <= 1'b0;
                        oe_b_ff <= 1'b1;
                        we_b_ff <= 1'b1;
                        dq_oe_ff <= 1'b0;
                        cnt_ff <= RST_CYC - 8'h01;
                        state_ff <= S_RLOW;
                    end
                end
                S_RLOW: begin
                    cnt_ff <= cnt_ff - 8'h01;
                    if (cnt_ff == 8'h00) begin
                        rst_pin_b_ff <= 1'b1;
                        cnt_ff <= EXIT_CYC - 8'h01;
                        state_ff <= S_RWAIT;
                    end
                end
                S_RWAIT: begin
                    cnt_ff <= cnt_ff - 8'h01;
                    if (cnt_ff == 8'h00) begin
                        mode_ff <= `MODE_ARRAY;
                        // Ask for status to learn whether a job was cut short
                        dq_out_ff <= {8'h00, `FC_READ_STATUS};
                        dq_oe_ff <= 1'b1;
                        ce_b_ff <= 1'b0;
                        two_ff <= 1'b0;
                        rd_pend_ff <= 1'b1;
                        after_rst_ff <= 1'b1;
                        pmode_ff <= `MODE_STATUS;
                        state_ff <= S_WSET;
                    end
                end
                S_WSET: begin
                    we_b_ff <= 1'b0;
                    cnt_ff <= WP_CYC - 8'h01;
                    state_ff <= S_WPUL;
                end
                S_WPUL: begin
                    cnt_ff <= cnt_ff - 8'h01;
                    if (cnt_ff == 8'h00) begin
                        we_b_ff <= 1'b1;
                        state_ff <= S_WHLD;
                    end
                end
                S_WHLD: begin
                    // Select rises after the write strobe; data still driven here
                    ce_b_ff <= 1'b1;
                    dq_oe_ff <= 1'b0;
                    state_ff <= S_GAP;
                end
                S_RACC: begin
                    cnt_ff <= cnt_ff - 8'h01;
                    if (cnt_ff == 8'h00) begin
                        rdata_ff <= data_pins_in;
                        if (after_rst_ff) begin
                            clean_ff <= (data_pins_in == `SR_AFTER_RESET);
                            after_rst_ff <= 1'b0;
                        end
                        // Both rise so the next read latches fresh status
                        ce_b_ff <= 1'b1;
                        oe_b_ff <= 1'b1;
                        rd_pend_ff <= 1'b0;
                        state_ff <= S_GAP;
                    end
                end
                S_GAP: begin
                    if (two_ff) begin
                        dq_out_ff <= w2_ff;
                        dq_oe_ff <= 1'b1;
                        ce_b_ff <= 1'b0;
                        two_ff <= 1'b0;
                        state_ff <= S_WSET;
                    end else if (rd_pend_ff) begin
                        ce_b_ff <= 1'b0;
                        oe_b_ff <= 1'b0;
                        cnt_ff <= ACC_CYC - 8'h01;
                        state_ff <= S_RACC;
                    end else begin
                        mode_ff <= pmode_ff;
                        wp_ff <= cfg_wp_ff;
                        state_ff <= S_IDLE;
                    end
                end
                default: begin
                    ce_b_ff <= 1'b1;
                    oe_b_ff <= 1'b1;
                    we_b_ff <= 1'b1;
                    dq_oe_ff <= 1'b0;
                    state_ff <= S_IDLE;
                end
            endcase
        end
    end

    assign reg_rdata = bus_rdata_ff;
    assign flash_addr = fa_ff;
    assign data_pins_out = dq_out_ff;
    assign data_pins_oe = dq_oe_ff;
    assign flash_ce_b = ce_b_ff;
    assign flash_oe_b = oe_b_ff;
    assign flash_we_b = we_b_ff;
    assign flash_rst_b = rst_pin_b_ff;
    assign flash_wp = wp_ff;

endmodule // flash_host_ctrl
`default_nettype wire

// File: rtl/flash_host_regs.vh
`ifndef FLASH_HOST_REGS_VH
`define FLASH_HOST_REGS_VH

// Register offsets of the controller
`define REG_CMD 8'h00
`define REG_ADDR 8'h04
`define REG_WDATA 8'h08
`define REG_RDATA 8'h0C
`define REG_STAT 8'h10
`define REG_CFG 8'h14

// Order word fields
`define CMD_OP_LSB 0
`define CMD_OP_MSB 2
`define CMD_CODE_LSB 8
`define CMD_CODE_MSB 15

// Order kinds
`define OP_SINGLE 3'h1
`define OP_SEQ 3'h2
`define OP_READ 3'h3
`define OP_RESET 3'h4

// Flash command codes
`define FC_READ_ARRAY 8'hFF
`define FC_READ_CONFIG 8'h90
`define FC_READ_QUERY 8'h98
`define FC_READ_STATUS 8'h70
`define FC_CLEAR_STATUS 8'h50
`define FC_ERASE_SETUP 8'h20
`define FC_CONFIRM 8'hD0
`define FC_WRITE_SETUP 8'h40
`define FC_WRITE_ALT 8'h10
`define FC_SUSPEND 8'hB0
`define FC_LOCK_SETUP 8'h60
`define FC_PROT_SETUP 8'hC0

// Tracked device read modes
`define MODE_ARRAY 2'h0
`define MODE_CONFIG 2'h1
`define MODE_QUERY 2'h2
`define MODE_STATUS 2'h3

// Status register bits
`define STAT_BUSY 0
`define STAT_REFUSED 1
`define STAT_MODE_LSB 2
`define STAT_MODE_MSB 3
`define STAT_SUPPLY 4
`define STAT_CLEAN 5

// Config register bits
`define CFG_WP 0

// Reset values
`define CFG_WP_RST 1'h0
`define SR_AFTER_RESET 16'h0080

// Timing
`define CLK_PERIOD_NS 20
`define RST_LOW_NS 100
`define RST_LOW_CYC ((`RST_LOW_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define WR_PULSE_CYC_DEF 8'h03
`define ACCESS_CYC_DEF 8'h06
`define EXIT_CYC_DEF 8'h04

`endif

// File: rtl/flash_host_ctrl_unused_none.v
`timescale 1ns/10ps
`default_nettype none
`default_nettype wire

// File: verification/flash_host_ctrl_properties.sv
`timescale 1ns/10ps
`default_nettype none

module flash_host_ctrl_properties #(
    parameter logic [7:0] WP_CYC = 8'h03,
    parameter logic [7:0] RST_CYC = 8'h05
) (
    input wire logic clk_sys,
    input wire logic rst_b,
    input wire logic reg_rd,
    input wire logic [31:0] reg_rdata,
    input wire logic [15:0] data_pins_out,
    input wire logic data_pins_oe,
    input wire logic flash_ce_b,
    input wire logic flash_oe_b,
    input wire logic flash_we_b,
    input wire logic flash_rst_b,
    input wire logic flash_wp
);
    default clocking @(posedge clk_sys); endclocking
    default disable iff (!rst_b);
    logic [7:0] we_lo_ff;
    logic [7:0] rst_lo_ff;
    ////////////////////////////////////////////////////////////////////////////////
    // Length of the current write strobe and flash reset pulses
    always_ff @(posedge clk_sys or negedge rst_b) begin
        if (!rst_b) begin
            we_lo_ff <= 8'h00;
            rst_lo_ff <= 8'h00;
        end else begin
            we_lo_ff <= flash_we_b ? 8'h00 : we_lo_ff + 8'h01;
            rst_lo_ff <= flash_rst_b ? 8'h00 : rst_lo_ff + 8'h01;
        end
    end
    ////////////////////////////////////////////////////////////////////////////////
    standby_float_a: assert property (flash_ce_b |-> !data_pins_oe && flash_oe_b)
        else $error("data driven while deselected");
    read_no_drive_a: assert property (!flash_oe_b |-> !flash_ce_b && flash_we_b && !data_pins_oe)
        else $error("bad pin levels during read");
    write_levels_a: assert property (!flash_we_b |-> !flash_ce_b && data_pins_oe && flash_rst_b)
        else $error("bad pin levels during write");
    write_hold_a: assert property (!flash_we_b |=> $stable(data_pins_out))
        else $error("write data moved before strobe rise");
    strobe_width_a: assert property ($rose(flash_we_b) |-> we_lo_ff == WP_CYC)
        else $error("write strobe width wrong");
    reset_width_a: assert property ($rose(flash_rst_b) |-> rst_lo_ff >= RST_CYC)
        else $error("flash reset pulse too short");
    reset_quiet_a: assert property (!flash_rst_b |-> flash_ce_b && flash_we_b && !data_pins_oe)
        else $error("flash active during reset");
    setup_protect_a: assert property ($fell(flash_we_b) &&
        data_pins_out[7:0] inside {8'h20, 8'h40, 8'h10, 8'h60} |-> flash_wp)
        else $error("write protect low for setup");
    rdata_idle_a: assert property (!reg_rd |=> reg_rdata == 32'h00000000)
        else $error("read data outside its cycle");
    cover property ($rose(flash_we_b));
    cover property ($rose(flash_rst_b));
    cover property ($fell(flash_oe_b));
endmodule // flash_host_ctrl_properties

bind flash_host_ctrl flash_host_ctrl_properties #(.WP_CYC(WP_CYC), .RST_CYC(RST_CYC))
    flash_host_ctrl_properties_inst (
    .clk_sys(clk_sys), .rst_b(rst_b), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
    .data_pins_out(data_pins_out), .data_pins_oe(data_pins_oe), .flash_ce_b(flash_ce_b),
    .flash_oe_b(flash_oe_b), .flash_we_b(flash_we_b), .flash_rst_b(flash_rst_b),
    .flash_wp(flash_wp));
`default_nettype wire

// File: verification/flash_device_model.sv
`timescale 1ns/10ps
`default_nettype none

module flash_device_model #(
    parameter logic [15:0] MAKER_ID = 16'h1A5A, // Arbitrary value
    parameter logic [15:0] QUERY_WORD = 16'h0051
) (
    input wire logic [21:0] addr,
    input wire logic [15:0] din,
    output logic [15:0] dout,
    input wire logic ce_b,
    input wire logic oe_b,
    input wire logic we_b,
    input wire logic rst_pin_b,
    input wire logic wp,
    input wire logic supply_ok
);
    logic [1:0] mode;
    logic [7:0] setup, sr, sr_latch;
    logic [1:0] lock;
    logic [15:0] prot, rd_val, last = 16'h0000;
    logic [15:0] mem [0:15];
    ////////////////////////////////////////////////////////////////////////////////
    // Power-up and reset state: array read, status 80H, sector locked
    task automatic reset_state();
        mode = 2'h0;
        sr = 8'h80;
        lock = 2'b01;
        setup = 8'h00;
    endtask
    initial reset_state();
    always @(negedge rst_pin_b) reset_state();
    // Command capture at the first rise of strobe or select; jobs end at once
    always @(posedge we_b or posedge ce_b) begin
        if (rst_pin_b && !(we_b && ce_b)) begin
            if (setup != 8'h00) begin
                case (setup)
                    8'h20: if (din[7:0] == 8'hD0 && supply_ok) mem[addr[3:0]] = 16'hFFFF;
                    8'h60: lock = din[7:0] == 8'h01 ? 2'b01 : din[7:0] == 8'h2F ? 2'b11 : 2'b00;
                    8'hC0: prot = din;
                    default: if (supply_ok && wp) mem[addr[3:0]] = din;
                endcase
                setup = 8'h00;
                mode = 2'h3;
            end else begin
                case (din[7:0])
                    8'hFF: mode = 2'h0;
                    8'h90: mode = 2'h1;
                    8'h98: mode = 2'h2;
                    8'h70: mode = 2'h3;
                    8'h50: sr = 8'h80;
                    8'hB0, 8'hD0: mode = 2'h3;
                    8'h20, 8'h40, 8'h10, 8'h60, 8'hC0: setup = din[7:0];
                    default: ;
                endcase
            end
        end
    end
    // Status held from the falling select or output enable
    always @(negedge ce_b or negedge oe_b) sr_latch = sr;
    // Read value by mode and address
    always @* begin
        case (mode)
            2'h0: rd_val = mem[addr[3:0]];
            2'h1: rd_val = addr[7:0] == 8'h00 ? MAKER_ID : addr[1:0] == 2'b10 ? {14'h0, lock} : prot;
            2'h2: rd_val = QUERY_WORD;
            default: rd_val = {8'h00, sr_latch};
        endcase
    end
    always @(posedge oe_b) last = rd_val;
    // Released bus shows the inverse of the last value
    assign dout = (!ce_b && !oe_b && we_b && rst_pin_b) ? rd_val : ~last;
endmodule // flash_device_model
`default_nettype wire

// File: verification/test_flash_host_ctrl.sv
`timescale 1ns/10ps
`default_nettype none
`include "flash_host_regs.vh"

module test_flash_host_ctrl;
    logic clk_sys = 1'b0, rst_b = 1'b0, reg_wr = 1'b0, reg_rd = 1'b0, prog_supply_ok = 1'b1;
    logic [7:0] reg_addr = 8'h00;
    logic [31:0] reg_wdata = 32'h0, rv;
    wire [31:0] reg_rdata;
    wire [21:0] flash_addr;
    wire [15:0] data_pins_out, dev_q, pins;
    wire data_pins_oe, flash_ce_b, flash_oe_b, flash_we_b, flash_rst_b, flash_wp;
    int miscompares = 0, n_compared = 0;
    initial forever #10 clk_sys = ~clk_sys;
    assign pins = data_pins_oe ? data_pins_out : dev_q;
    flash_host_ctrl #(.WP_CYC(8'h03), .ACC_CYC(8'h06), .EXIT_CYC(8'h04)) flash_host_ctrl_inst (
        .clk_sys(clk_sys), .rst_b(rst_b), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
        .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .prog_supply_ok(prog_supply_ok),
        .flash_addr(flash_addr), .data_pins_in(pins), .data_pins_out(data_pins_out),
        .data_pins_oe(data_pins_oe), .flash_ce_b(flash_ce_b), .flash_oe_b(flash_oe_b),
        .flash_we_b(flash_we_b), .flash_rst_b(flash_rst_b), .flash_wp(flash_wp));
    flash_device_model flash_device_model_inst (.addr(flash_addr), .din(pins), .dout(dev_q),
        .ce_b(flash_ce_b), .oe_b(flash_oe_b), .we_b(flash_we_b), .rst_pin_b(flash_rst_b),
        .wp(flash_wp), .supply_ok(prog_supply_ok));
    ////////////////////////////////////////////////////////////////////////////////
    task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
        n_compared++;
        if (seen !== exp) begin
            miscompares++;
            $display("wrong value %s expected %h seen %h", what, exp, seen);
        end
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge clk_sys);
        reg_addr <= a;
        reg_wdata <= d;
        reg_wr <= 1'b1;
        @(posedge clk_sys);
        reg_wr <= 1'b0;
    endtask
    task automatic rd(input logic [7:0] a, output logic [31:0] d);
        @(posedge clk_sys);
        reg_addr <= a;
        reg_rd <= 1'b1;
        @(posedge clk_sys);
        reg_rd <= 1'b0;
        @(negedge clk_sys);
        d = reg_rdata;
    endtask
    // Issue one order and wait for busy to drop
    task automatic order(input logic [2:0] op, input logic [7:0] code, input logic [21:0] a,
        input logic [15:0] d);
        int n;
        wr(`REG_ADDR, {10'h0, a});
        wr(`REG_WDATA, {16'h0, d});
        wr(`REG_CMD, {16'h0, code, 5'h0, op});
        n = 0;
        rv = 32'h1;
        while (rv[0] && n < 200) begin
            rd(`REG_STAT, rv);
            n++;
        end
        chk("busy", rv[0], 32'h0);
    endtask
    // Read one flash word through a read order
    task automatic fread(input logic [21:0] a, input logic [15:0] exp, input string what);
        order(`OP_READ, 8'h00, a, 16'h0);
        rd(`REG_RDATA, rv);
        chk(what, rv, {16'h0, exp});
    endtask
    task automatic stop_test();
        if (miscompares == 0 && n_compared > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask
    ////////////////////////////////////////////////////////////////////////////////
    initial begin
        #200000;
        miscompares++;
        stop_test();
    end
    initial begin
        repeat (2) @(posedge clk_sys);
        rst_b <= 1'b1;
        rd(`REG_CFG, rv);
        chk("cfg", rv, 32'h0);
        rd(8'h18, rv);
        chk("unmapped", rv, 32'h0);
        order(`OP_RESET, 8'h00, 22'h0, 16'h0);
        chk("stat after reset", rv, 32'h3C);
        rd(`REG_RDATA, rv);
        chk("status word", rv, 32'h80);
        order(`OP_SEQ, 8'h40, 22'h3, 16'h1234);
        order(`OP_SEQ, 8'h10, 22'h5, 16'h5678);
        order(`OP_SINGLE, 8'hFF, 22'h0, 16'h0);
        chk("array mode", rv[3:2], 32'h0);
        fread(22'h3, 16'h1234, "word a");
        fread(22'h5, 16'h5678, "word b");
        order(`OP_SEQ, 8'h20, 22'h3, 16'h0);
        order(`OP_SINGLE, 8'hFF, 22'h0, 16'h0);
        fread(22'h3, 16'hFFFF, "erased");
        order(`OP_SINGLE, 8'h90, 22'h0, 16'h0);
        fread(22'h0, 16'h1A5A, "maker");
        fread(22'h2, 16'h0001, "locked");
        order(`OP_SEQ, 8'h60, 22'h2, 16'h002F);
        order(`OP_SINGLE, 8'h90, 22'h0, 16'h0);
        fread(22'h2, 16'h0003, "lock down");
        order(`OP_SEQ, 8'h60, 22'h2, 16'h00D0);
        order(`OP_SEQ, 8'hC0, 22'h81, 16'hABCD);
        order(`OP_SINGLE, 8'h90, 22'h0, 16'h0);
        fread(22'h2, 16'h0000, "unlocked");
        fread(22'h81, 16'hABCD, "protection");
        order(`OP_SINGLE, 8'h98, 22'h0, 16'h0);
        fread(22'h10, 16'h0051, "query");
        order(`OP_SINGLE, 8'h50, 22'h0, 16'h0);
        order(`OP_SINGLE, 8'h70, 22'h0, 16'h0);
        fread(22'h3, 16'h0080, "status read");
        fread(22'h7, 16'h0080, "status again");
        order(`OP_SINGLE, 8'hB0, 22'h0, 16'h0);
        chk("suspend", rv, 32'h3C);
        order(`OP_SINGLE, 8'hD0, 22'h0, 16'h0);
        chk("resume", rv, 32'h3C);
        @(posedge clk_sys);
        prog_supply_ok <= 1'b0;
        order(`OP_SEQ, 8'h20, 22'h3, 16'h0);
        chk("supply refusal", rv[4:1], 32'h7);
        wr(`REG_STAT, 32'h2);
        order(`OP_SEQ, 8'hC0, 22'h82, 16'h1111);
        chk("prot low supply", rv[1], 32'h0);
        order(`OP_SINGLE, 8'h33, 22'h0, 16'h0);
        chk("bad code", rv[1], 32'h1);
        wr(`REG_STAT, 32'h2);
        rd(`REG_STAT, rv);
        chk("refusal cleared", rv[1], 32'h0);
        stop_test();
    end
endmodule // test_flash_host_ctrl
`default_nettype wire
